/* lpw_raster.sv */
// line pattern masking and wide line fragment expansion
// What this block does
// - only the low 16 bits of a supplied pattern are kept.
// - repeat factor clamped to 1..256; each bit covers that many fragments.
// - with patterning off, no fragment is suppressed.
// - bit index is counter divided by factor, modulo 16; emit when bit set.
// - index 0 is the least significant pattern bit, 15 the most.
// - counter starts at zero, steps once per position from start to end.
// - counter clears on each new group and each independent segment.
// - clipped segments may start with any counter value.
// - width rounds to nearest, clamps to maximum, zero becomes one.
// - maximum non-antialiased width is at least antialiased maximum, at least 1.
// - shift by (w-1)/2 in minor axis, emit w fragments per position.
// - one pattern bit decides a whole minor column.
// - antialiased coverage is the area inside the segment rectangle.
// - antialiased width 1.0 is supported; only the maximum, 1, is reported, on aa_width_max.
// - antialiased patterned lines split into unit pieces kept per pattern.
// - reset holds width 1.0, no antialias, pattern FFFF, factor 1, pattern off.
// - multisample coverage bit set only inside a retained piece.
module lpw_raster
    import lpw_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic set_line_pattern_command,
    input wire logic [31:0] pattern_in,
    input wire logic [31:0] factor_in,
    input wire logic set_width,
    input wire logic [lpw_pkg::WID_W-1:0] width_in,
    input wire logic set_enables,
    input wire logic line_antialias_enable_in,
    input wire logic pattern_enable_in,
    input wire logic multisample_enable,
    input wire logic [1:0] sample_buffer_count,
    input wire logic group_begin,
    input wire logic seg_valid,
    input wire logic seg_first,
    input wire logic seg_x_major,
    input wire logic [lpw_pkg::COORD_W-1:0] seg_major,
    input wire logic [lpw_pkg::COORD_W-1:0] seg_minor,
    input wire logic seg_last,
    input wire logic [lpw_pkg::SMP_W-1:0] seg_sample_in,
    input wire logic [lpw_pkg::SMP_W-1:0] seg_piece_in,
    output logic seg_ready,
    output logic frag_valid,
    output logic [lpw_pkg::COORD_W-1:0] frag_x,
    output logic [lpw_pkg::COORD_W-1:0] frag_y,
    output logic [lpw_pkg::SMP_W-1:0] frag_coverage,
    output logic frag_aa,
    output logic [lpw_pkg::WID_W-1:0] width_q,
    output logic line_antialias_enable,
    output logic [lpw_pkg::PAT_W-1:0] pattern_q,
    output logic [lpw_pkg::FAC_W-1:0] factor_q,
    output logic pattern_enable,
    output logic [lpw_pkg::INT_W-1:0] aa_width_max
);
    import lpw_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COL = 2'b10
    } lpw_state_t;

    typedef struct packed {
        lpw_state_t state;
        logic [WID_W-1:0] width;
        logic aa;
        logic [PAT_W-1:0] pat;
        logic [FAC_W-1:0] fac;
        logic pen;
        logic [INT_W-1:0] col;
        logic [INT_W-1:0] w;
        logic xmaj;
        logic [COORD_W-1:0] maj;
        logic [COORD_W-1:0] mnr;
        logic keep;
        logic [SMP_W-1:0] cov;
        logic fv;
        logic [COORD_W-1:0] fx;
        logic [COORD_W-1:0] fy;
        logic [SMP_W-1:0] fcov;
        logic faa;
    } lpw_st_t;

    lpw_st_t st_r, st_nxt;
    logic [INT_W-1:0] wint;
    logic keep_bit;
    logic take;
    logic pat_clear;
    logic ms_mode;

    function automatic logic [FAC_W-1:0] clamp_factor(input logic [31:0] f);
        if ($signed(f) < $signed({23'h0, FAC_MIN}))
            return FAC_MIN;
        else if ($signed(f) > $signed({23'h0, FAC_MAX}))
            return FAC_MAX;
        else
            return f[FAC_W-1:0];
    endfunction

    // truncates toward zero, so an even width places its extra fragment above the walked line
    function automatic logic [COORD_W-1:0] half_down(input logic [INT_W-1:0] w);
        logic [INT_W-1:0] h;
        h = (w - WID_ONE) >> 1;
        return {{(COORD_W-INT_W){1'b0}}, h};
    endfunction

    lpw_width u_width (
        .width_fx(st_r.width),
        .width_int(wint)
    );

    assign take = seg_valid && (st_r.state == ST_IDLE);
    // group start and each independent segment clear the counter
    assign pat_clear = group_begin || (take && seg_first);

    lpw_pattern u_pattern (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .clear(pat_clear),
        .step(take),
        .pattern(st_r.pat),
        .factor(st_r.fac),
        .enable(st_r.pen),
        .keep(keep_bit)
    );
    // counter steps after each position; the bit read now is the pre-step one
    // a clipped segment just arrives without seg_first, its start value is free

    assign ms_mode = multisample_enable && (sample_buffer_count == 2'h1);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fv = 1'b0;
        if (set_line_pattern_command)
        begin
            st_nxt.pat = pattern_in[PAT_W-1:0];
            st_nxt.fac = clamp_factor(factor_in);
        end
        if (set_width)
            st_nxt.width = width_in;
        if (set_enables)
        begin
            st_nxt.aa = line_antialias_enable_in;
            st_nxt.pen = pattern_enable_in;
        end
        case (st_r.state)
            ST_IDLE:
            begin
                if (take)
                begin
                    st_nxt.xmaj = seg_x_major;
                    st_nxt.maj = seg_major;
                    st_nxt.keep = pat_clear ? (!st_r.pen || st_r.pat[0]) : keep_bit;
                    // coverage gated by retained piece; only multisample mode passes it to frag_coverage
                    st_nxt.cov = seg_sample_in & seg_piece_in;
                    if (st_r.aa || ms_mode)
                    begin
                        // area coverage comes from setup; one fragment per piece
                        st_nxt.fv = st_nxt.keep;
                        st_nxt.fx = seg_x_major ? seg_major : seg_minor;
                        st_nxt.fy = seg_x_major ? seg_minor : seg_major;
                        st_nxt.fcov = ms_mode ? st_nxt.cov : seg_sample_in;
                        st_nxt.faa = 1'b1;
                    end
                    else
                    begin
                        st_nxt.w = wint;
                        st_nxt.mnr = seg_minor - half_down(wint);
                        st_nxt.col = '0;
                        st_nxt.state = ST_COL;
                    end
                end
            end
            ST_COL:
            begin
                // whole column kept or dropped by one bit
                st_nxt.fv = st_r.keep;
                st_nxt.fx = st_r.xmaj ? st_r.maj : st_r.mnr + COORD_W'(st_r.col);
                st_nxt.fy = st_r.xmaj ? st_r.mnr + COORD_W'(st_r.col) : st_r.maj;
                st_nxt.fcov = {SMP_W{1'b1}};
                st_nxt.faa = 1'b0;
                st_nxt.col = st_r.col + WID_ONE;
                if (st_r.col + WID_ONE >= st_r.w)
                    st_nxt.state = ST_IDLE;
            end
            default:
            begin
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
            st_r.state <= ST_IDLE;
            st_r.width <= WID_RESET;
            st_r.pat <= PAT_RESET;
            st_r.fac <= FAC_RESET;
            st_r.aa <= 1'b0;
            st_r.pen <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // one-hot: bit 0 is the idle state, so ready comes straight from a flop
    assign seg_ready = st_r.state[0];
    assign frag_valid = st_r.fv;
    assign frag_x = st_r.fx;
    assign frag_y = st_r.fy;
    assign frag_coverage = st_r.fcov;
    assign frag_aa = st_r.faa;
    assign width_q = st_r.width;
    assign line_antialias_enable = st_r.aa;
    assign pattern_q = st_r.pat;
    assign factor_q = st_r.fac;
    assign pattern_enable = st_r.pen;
    assign aa_width_max = WID_MAX_AA_INT;

    property p_reset_defaults;
        @(posedge mclk) $rose(resetn) |-> (pattern_q == PAT_RESET) && (factor_q == FAC_RESET);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state");

    property p_factor_range;
        @(posedge mclk) disable iff (!resetn) (factor_q >= FAC_MIN) && (factor_q <= FAC_MAX);
    endproperty
    a_factor_range: assert property (p_factor_range) else $error("factor out of range");

    property p_pattern_low;
        @(posedge mclk) disable iff (!resetn) ce && set_line_pattern_command
            |=> pattern_q == $past(pattern_in[PAT_W-1:0]);
    endproperty
    a_pattern_low: assert property (p_pattern_low) else $error("pattern not low bits");

    property p_no_mask_off;
        @(posedge mclk) disable iff (!resetn) ce && take && !st_r.pen && !st_r.aa && !ms_mode
            |=> st_r.keep;
    endproperty
    a_no_mask_off: assert property (p_no_mask_off) else $error("masked while disabled");

    sequence s_col_start;
        ce && take && !st_r.aa && !ms_mode;
    endsequence
    property p_col_enter;
        @(posedge mclk) disable iff (!resetn) s_col_start |=> st_r.state == ST_COL;
    endproperty
    a_col_enter: assert property (p_col_enter) else $error("no column walk");

    property p_col_keep;
        @(posedge mclk) disable iff (!resetn) st_r.state == ST_COL && ce
            |=> frag_valid == $past(st_r.keep);
    endproperty
    a_col_keep: assert property (p_col_keep) else $error("column not uniform");

    property p_width_nonzero;
        @(posedge mclk) disable iff (!resetn) (wint >= WID_ONE) && (wint <= WID_MAX_INT);
    endproperty
    a_width_nonzero: assert property (p_width_nonzero) else $error("width bad");

    property p_ms_cov;
        @(posedge mclk) disable iff (!resetn) ce && take && ms_mode
            |=> frag_coverage == ($past(seg_sample_in) & $past(seg_piece_in));
    endproperty
    a_ms_cov: assert property (p_ms_cov) else $error("coverage not gated");
endmodule

/* lpw_pkg.sv */
// shared constants for the line pattern and wide line fragment block
package lpw_pkg;
    localparam int PAT_W = 16;
    localparam int IDX_W = 4;
    localparam int FAC_W = 9;
    localparam int CNT_W = 8;
    localparam logic [PAT_W-1:0] PAT_RESET = 16'hFFFF;
    localparam logic [FAC_W-1:0] FAC_MIN = 9'h001;
    localparam logic [FAC_W-1:0] FAC_MAX = 9'h100;
    localparam logic [FAC_W-1:0] FAC_RESET = 9'h001;
    localparam int WID_W = 8;
    localparam int WID_FRAC = 4;
    localparam logic [WID_W-1:0] WID_RESET = 8'h10;
    localparam logic [WID_W-1:0] WID_HALF = 8'h08;
    localparam int INT_W = WID_W - WID_FRAC;
    localparam logic [INT_W-1:0] WID_ONE = 4'h1;
    localparam logic [INT_W-1:0] WID_MAX_INT = 4'hF;
    localparam logic [INT_W-1:0] WID_MAX_AA_INT = 4'h1;
    localparam int COORD_W = 12;
    localparam int SMP_W = 4;
endpackage

/* lpw_pattern.sv */
// pattern mask bit selection with repeat sub-counter and bit index
module lpw_pattern
    import lpw_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic step,
    input wire logic [lpw_pkg::PAT_W-1:0] pattern,
    input wire logic [lpw_pkg::FAC_W-1:0] factor,
    input wire logic enable,
    output logic keep
);
    typedef struct packed {
        logic [lpw_pkg::FAC_W-1:0] rep;
        logic [lpw_pkg::IDX_W-1:0] idx;
    } lpw_pat_st_t;
    lpw_pat_st_t st_r, st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // a position taken together with the clear still counts, so the next one sees one
        if (clear)
        begin
            st_nxt = '0;
        end
        if (step)
        begin
            // sub-counter wraps at the factor, index advances on wrap
            if (st_nxt.rep + FAC_MIN >= factor)
            begin
                st_nxt.rep = '0;
                st_nxt.idx = st_nxt.idx + IDX_W'(1);
            end
            else
            begin
                st_nxt.rep = st_nxt.rep + FAC_MIN;
            end
        end
    end

    // index 0 is the lsb; disabled pattern behaves as all ones
    assign keep = !enable || pattern[st_r.idx];

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end
endmodule

/* lpw_width.sv */
// width rounding and clamping for non-antialiased lines
module lpw_width
    import lpw_pkg::*;
(
    input wire logic [lpw_pkg::WID_W-1:0] width_fx,
    output logic [lpw_pkg::INT_W-1:0] width_int
);
    logic [WID_W:0] sum;
    logic [INT_W:0] rounded;
    // round to nearest, zero becomes one, clamp to maximum
    always_comb
    begin
        sum = {1'b0, width_fx} + {1'b0, WID_HALF};
        rounded = sum[WID_W:WID_FRAC];
        if (rounded == '0)
            width_int = WID_ONE;
        else if (rounded > {1'b0, WID_MAX_INT})
            width_int = WID_MAX_INT;
        else
            width_int = rounded[INT_W-1:0];
    end
endmodule

/* lpw_seg_src.sv */
// upstream setup stage model offering one walked line position at a time
module lpw_seg_src
    import lpw_pkg::*;
(
    input wire logic mclk,
    input wire logic seg_ready,
    output logic seg_valid,
    output logic seg_first,
    output logic seg_x_major,
    output logic [lpw_pkg::COORD_W-1:0] seg_major,
    output logic [lpw_pkg::COORD_W-1:0] seg_minor,
    output logic seg_last,
    output logic [lpw_pkg::SMP_W-1:0] seg_sample_in,
    output logic [lpw_pkg::SMP_W-1:0] seg_piece_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {seg_valid, seg_first, seg_x_major, seg_major, seg_minor, seg_last} = '0;
        {seg_sample_in, seg_piece_in} = '0;
    end
    // entered just after an edge; holds the offer until the edge that takes it
    task automatic send(input logic f, input logic xm, input logic [11:0] ma, input logic [11:0] mi,
        input logic [3:0] sm, input logic [3:0] pc);
        int n;
        n = 0;
        {seg_valid, seg_first, seg_x_major, seg_major, seg_minor} = {1'b1, f, xm, ma, mi};
        {seg_last, seg_sample_in, seg_piece_in} = {1'b0, sm, pc};
        while (seg_ready !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= 50)
            tb_top.bad_count++;
        @(posedge mclk);
        #1;
    endtask
    // released lines flip so stale values cannot pass for fresh ones
    task automatic idle();
        seg_valid = 0;
        {seg_first, seg_major, seg_minor} = ~{seg_first, seg_major, seg_minor};
        {seg_sample_in, seg_piece_in} = ~{seg_sample_in, seg_piece_in};
    endtask
endmodule

/* tb_top.sv */
// self-checking bench comparing fragments with a queue-based reference model
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lpw_pkg::*;
    logic mclk, resetn, ce, set_line_pattern_command, set_width, set_enables, group_begin;
    logic line_antialias_enable_in, pattern_enable_in, multisample_enable;
    logic [31:0] pattern_in, factor_in;
    logic [WID_W-1:0] width_in, width_q;
    logic [1:0] sample_buffer_count;
    logic seg_valid, seg_first, seg_x_major, seg_last, seg_ready, frag_valid, frag_aa;
    logic line_antialias_enable, pattern_enable;
    logic [COORD_W-1:0] seg_major, seg_minor, frag_x, frag_y;
    logic [SMP_W-1:0] seg_sample_in, seg_piece_in, frag_coverage;
    logic [PAT_W-1:0] pattern_q;
    logic [FAC_W-1:0] factor_q;
    logic [INT_W-1:0] aa_width_max;
    int bad_count, checks_done, s_m, r_m, w_m;
    logic [15:0] p_m;
    bit pe_m, ms_m, aa_m;
    logic [28:0] exp_q[$], got_q[$];
    int fac_tab[6] = '{0, 1, 256, 300, -5, 7};
    logic [7:0] wid_tab[5] = '{8'h10, 8'h07, 8'h2C, 8'hFF, 8'h21};

    lpw_raster lpw_raster_i (.mclk, .resetn, .ce, .set_line_pattern_command, .pattern_in,
        .factor_in, .set_width, .width_in, .set_enables, .line_antialias_enable_in,
        .pattern_enable_in, .multisample_enable, .sample_buffer_count, .group_begin,
        .seg_valid, .seg_first, .seg_x_major, .seg_major, .seg_minor, .seg_last, .seg_sample_in,
        .seg_piece_in, .seg_ready, .frag_valid, .frag_x, .frag_y, .frag_coverage, .frag_aa,
        .width_q, .line_antialias_enable, .pattern_q, .factor_q, .pattern_enable, .aa_width_max);
    lpw_seg_src lpw_seg_src_i (.mclk, .seg_ready, .seg_valid, .seg_first, .seg_x_major,
        .seg_major, .seg_minor, .seg_last, .seg_sample_in, .seg_piece_in);

    initial
    begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (frag_valid === 1'b1)
            got_q.push_back({frag_aa, frag_aa ? frag_coverage : 4'h0, frag_x, frag_y});

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic pulse(ref logic sig);
        sig = 1;
        @(posedge mclk);
        #1 sig = 0;
    endtask
    task automatic cfg_pat(input logic [31:0] p, input int f);
        {pattern_in, factor_in} = {p, f};
        pulse(set_line_pattern_command);
        p_m = p[15:0];
        r_m = f < 1 ? 1 : (f > 256 ? 256 : f);
        chk("pattern_q", pattern_q, p_m);
        chk("factor_q", factor_q, r_m);
    endtask
    task automatic cfg_w(input logic [7:0] wd);
        width_in = wd;
        pulse(set_width);
        w_m = (wd + 8) >> 4;
        w_m = w_m == 0 ? 1 : (w_m > 15 ? 15 : w_m);
        chk("width_q", width_q, wd);
    endtask
    task automatic cfg_en(input bit aa, input bit pe);
        {line_antialias_enable_in, pattern_enable_in} = {aa, pe};
        pulse(set_enables);
        pe_m = pe;
        aa_m = aa;
        chk("enables", {line_antialias_enable, pattern_enable}, {aa, pe});
    endtask
    task automatic pos(input bit f, input bit xm, input logic [11:0] ma, input logic [11:0] mi,
        input logic [3:0] sm, input logic [3:0] pc);
        logic [11:0] mn;
        bit keep;
        if (f)
            s_m = 0;
        keep = !pe_m || p_m[(s_m / r_m) % 16];
        s_m++;
        if (keep && (ms_m || aa_m))
            exp_q.push_back({1'b1, ms_m ? sm & pc : sm, xm ? ma : mi, xm ? mi : ma});
        else if (keep)
            for (int k = 0; k < w_m; k++)
            begin
                mn = mi - 12'((w_m - 1) / 2) + 12'(k);
                exp_q.push_back({5'h00, xm ? ma : mn, xm ? mn : ma});
            end
        lpw_seg_src_i.send(f, xm, ma, mi, sm, pc);
    endtask
    task automatic flush();
        lpw_seg_src_i.idle();
        repeat (40) @(posedge mclk);
        #1 chk("frag_count", got_q.size(), exp_q.size());
        for (int i = 0; i < got_q.size() && i < exp_q.size(); i++)
            chk("fragment", got_q[i], exp_q[i]);
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #400000 bad_count++;
        end_sim();
    end
    initial
    begin
        {resetn, set_line_pattern_command, set_width, set_enables, group_begin} = '0;
        {line_antialias_enable_in, pattern_enable_in, multisample_enable} = '0;
        {pattern_in, factor_in, width_in, sample_buffer_count} = '0;
        ce = 1;
        void'($urandom(32'h7ff8));
        repeat (8) @(posedge mclk);
        #1 resetn = 1;
        chk("reset_state", {width_q, line_antialias_enable, pattern_enable},
            {WID_RESET, 1'b0, 1'b0});
        chk("reset_pattern", {pattern_q, factor_q}, {16'hFFFF, 9'h001});
        // with the clock enable low a load must not land
        ce = 0;
        pattern_in = $urandom;
        pulse(set_line_pattern_command);
        chk("ce_hold", pattern_q, 16'hFFFF);
        ce = 1;
        chk("aa_width_max", aa_width_max, 4'h1);
        foreach (fac_tab[i])
            cfg_pat(32'hABCD_0000 | $urandom, fac_tab[i]);
        cfg_en(0, 1);
        // one run per width, the last with patterning off and an all-zero mask
        foreach (wid_tab[j])
        begin
            cfg_w(wid_tab[j]);
            cfg_pat($urandom, j == 4 ? 1 : 1 + $urandom % 4);
            if (j == 4)
            begin
                cfg_pat(32'h0, 2);
                cfg_en(0, 0);
            end
            for (int i = 0; i < 40; i++)
            begin
                if (i == 20)
                begin
                    pulse(group_begin);
                    s_m = 0;
                end
                pos(i == 0 || i == 30, j[0], 12'(100 + i), 12'(200 + $urandom % 64), 0, 0);
            end
            flush();
        end
        cfg_w(8'h10);
        cfg_en(1, 1);
        cfg_pat(32'h0000_F0F5, 1);
        multisample_enable = 1;
        // two sample_buffer_count is not multisample mode, one is
        for (int m = 2; m > 0; m--)
        begin
            sample_buffer_count = 2'(m);
            ms_m = m == 1;
            for (int i = 0; i < 24; i++)
                pos(i == 0, 1, 12'(300 + i), 12'h050, 4'($urandom), 4'($urandom));
            flush();
        end
        end_sim();
    end
endmodule
